// ---- hw/hgd_cur_decode.v ----
// hgd_cur_decode.v: maps the 4-bit hs source and sink codes to peak currents in mA
// assumes: codes come straight from the config register flops
`timescale 1ns/100ps
module hgd_cur_decode (
    input  wire [3:0]  src_code,
    input  wire [3:0]  snk_code,
    output wire [10:0] src_ma,
    output wire [11:0] snk_ma
);

// ==========================================================
// lookup functions
function [10:0] src_lut;
    input [3:0] c;
    begin
        case (c)
            4'h0: src_lut = 11'd50;
            4'h1: src_lut = 11'd50;
            4'h2: src_lut = 11'd100;
            4'h3: src_lut = 11'd150;
            4'h4: src_lut = 11'd300;
            4'h5: src_lut = 11'd350;
            4'h6: src_lut = 11'd400;
            4'h7: src_lut = 11'd450;
            4'h8: src_lut = 11'd550;
            4'h9: src_lut = 11'd600;
            4'hA: src_lut = 11'd650;
            4'hB: src_lut = 11'd700;
            4'hC: src_lut = 11'd850;
            4'hD: src_lut = 11'd900;
            4'hE: src_lut = 11'd950;
            default: src_lut = 11'd1000;
        endcase
    end
endfunction

function [11:0] snk_lut;
    input [3:0] c;
    begin
        case (c)
            4'h0: snk_lut = 12'd100;
            4'h1: snk_lut = 12'd100;
            4'h2: snk_lut = 12'd200;
            4'h3: snk_lut = 12'd300;
            4'h4: snk_lut = 12'd600;
            4'h5: snk_lut = 12'd700;
            4'h6: snk_lut = 12'd800;
            4'h7: snk_lut = 12'd900;
            4'h8: snk_lut = 12'd1100;
            4'h9: snk_lut = 12'd1200;
            4'hA: snk_lut = 12'd1300;
            4'hB: snk_lut = 12'd1400;
            4'hC: snk_lut = 12'd1700;
            4'hD: snk_lut = 12'd1800;
            4'hE: snk_lut = 12'd1900;
            default: snk_lut = 12'd2000;
        endcase
    end
endfunction

// ==========================================================
// decode
// source and sink current tables
assign src_ma = src_lut(src_code);
assign snk_ma = snk_lut(snk_code);

endmodule // hgd_cur_decode

// ---- hw/hgd_defs.vh ----
// hgd_defs.vh: offsets, field positions, reset values and codes for the hs drive register
// assumes: included by bare name from the hgd design files
`ifndef HGD_DEFS_VH
`define HGD_DEFS_VH

// ==========================================================
// register indices (byte address = index * 4)
`define HGD_IDX_DRV_CTRL    8'h02
`define HGD_IDX_HS_CFG      8'h03
`define HGD_ADDR_DRV_CTRL   32'h0000_0008
`define HGD_ADDR_HS_CFG     32'h0000_000C

// ==========================================================
// field layout of high_side_drive_config
`define HGD_LOCK_MSB        10
`define HGD_LOCK_LSB        8
`define HGD_SRC_MSB         7
`define HGD_SRC_LSB         4
`define HGD_SNK_MSB         3
`define HGD_SNK_LSB         0
`define HGD_CFG_W           11

// ==========================================================
// lock codes and reset values
`define HGD_LOCK_SET        3'h6
`define HGD_LOCK_CLR        3'h3
`define HGD_RST_LOCK        3'h3
`define HGD_RST_SRC         4'hF
`define HGD_RST_SNK         4'hF
`define HGD_RST_DRV_CTRL    11'h000
`define HGD_DRV_OPEN_MASK   11'h007

`endif

// ---- hw/hgd_top.v ----
// hgd_top.v: hs gate drive config register with map-wide write lock, ahb-lite slave
// assumes: single ahb-lite master, word transfers only, inputs synchronous to hclk
// limitation: hsize is ignored, every access is taken as one full word
//
// Contract
// - register 0x03 read/write: lock 10-8, source code 7-4, sink code 3-0
// - writing 110b to lock locks; further code writes and driver control bits 3-10 discarded
// - while locked, lock bits and driver control bits 0-2 stay writable
// - while unlocked, lock values other than 110b do nothing
// - writing 011b unlocks; lock field resets to 011b, so starts unlocked
// - while locked, lock values other than 011b do nothing
// - source code decodes to 50..1000 mA peak per table
// - sink codes 0,1 give 100 mA, 2 gives 200, 3 gives 300
// - sink codes 4..15 give 600 to 2000 mA per table
`timescale 1ns/100ps
`include "hgd_defs.vh"
module hgd_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output wire [3:0]  hs_source_current_code,
    output wire [3:0]  hs_sink_current_code,
    output wire [10:0] hs_source_current_ma,
    output wire [11:0] hs_sink_current_ma,
    output wire [10:0] drv_ctrl_bits,
    output wire        cfg_locked
);

// ==========================================================
// state
reg  [2:0]  lock_q;
reg  [2:0]  lock_d;
reg  [3:0]  src_q;
reg  [3:0]  src_d;
reg  [3:0]  snk_q;
reg  [3:0]  snk_d;
reg  [10:0] drv_ctrl_q;
reg  [10:0] drv_ctrl_d;
reg         wr_pend_q;
reg  [31:0] wr_addr_q;
reg  [31:0] rd_word;
wire        locked;
wire        acc;
wire        wr_cfg;
wire        wr_drv;
wire [2:0]  lock_new;
wire [10:0] drv_open;
wire [10:0] drv_we;

// low bits of the driver control register that the lock leaves open
localparam [10:0] DRV_OPEN = `HGD_DRV_OPEN_MASK;
// register selects returned by map_sel
localparam [1:0]  SEL_NONE = 2'b00;
localparam [1:0]  SEL_DRV  = 2'b01;
localparam [1:0]  SEL_CFG  = 2'b10;

// ==========================================================
// decode helpers
// only the low address byte is decoded, so the map repeats every 256 bytes
function [1:0] map_sel;
    input [7:0] a;
    begin
        if ({24'h000000, a} == `HGD_ADDR_DRV_CTRL)
            map_sel = SEL_DRV;
        else if ({24'h000000, a} == `HGD_ADDR_HS_CFG)
            map_sel = SEL_CFG;
        else
            map_sel = SEL_NONE;
    end
endfunction

// next lock field from the stored field and the written pattern
function [2:0] lock_next;
    input [2:0] cur;
    input [2:0] wr;
    begin
        if (cur != `HGD_LOCK_SET && wr == `HGD_LOCK_SET)
            lock_next = `HGD_LOCK_SET;
        else if (cur == `HGD_LOCK_SET && wr == `HGD_LOCK_CLR)
            lock_next = `HGD_LOCK_CLR;
        // a write of 110b while already locked changes nothing
        else
            lock_next = cur;
    end
endfunction

// ==========================================================
// ahb address phase capture
// zero wait states: the write is applied in its data phase
// a read right behind a write to the same register returns the old value
assign acc       = hsel && hready && htrans[1];
assign hreadyout = 1'b1;
assign hresp     = 1'b0;

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        wr_pend_q <= 1'b0;
        wr_addr_q <= 32'h0000_0000;
    end
    else
    begin
        wr_pend_q <= acc && hwrite;
        if (acc)
            wr_addr_q <= haddr;
    end
end

// read word for the register in the current address phase
always @*
begin
    case (map_sel(haddr[7:0]))
        SEL_DRV: rd_word = {21'h000000, drv_ctrl_q};
        SEL_CFG: rd_word = {21'h000000, lock_q, src_q, snk_q};
        default: rd_word = 32'h0000_0000;
    endcase
end

// read data registered at the address phase so it is ready one edge later
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        hrdata <= 32'h0000_0000;
    else if (acc && !hwrite)
        hrdata <= rd_word;
end

// ==========================================================
// lock and register writes
assign locked   = (lock_q == `HGD_LOCK_SET);
assign wr_cfg   = wr_pend_q && (map_sel(wr_addr_q[7:0]) == SEL_CFG);
assign wr_drv   = wr_pend_q && (map_sel(wr_addr_q[7:0]) == SEL_DRV);
// lock field as written in the current data phase
assign lock_new = hwdata[`HGD_LOCK_MSB:`HGD_LOCK_LSB];

// per-bit write enables of the driver control register
genvar gi;
generate
    for (gi = 0; gi < `HGD_CFG_W; gi = gi + 1)
    begin : g_drv_we
        // low three bits stay writable under the lock
        assign drv_open[gi] = DRV_OPEN[gi] || !locked;
        assign drv_we[gi]   = wr_drv && drv_open[gi];
    end
endgenerate

// next values of the stored fields
always @*
begin
    lock_d     = lock_q;
    src_d      = src_q;
    snk_d      = snk_q;
    // fault-clear bit self clears one cycle after it is written
    drv_ctrl_d = {drv_ctrl_q[10:1], 1'b0};
    if (wr_cfg)
    begin
        lock_d = lock_next(lock_q, lock_new);
        // codes held while locked; an unlocking write stores no codes
        if (!locked)
        begin
            src_d = hwdata[`HGD_SRC_MSB:`HGD_SRC_LSB];
            snk_d = hwdata[`HGD_SNK_MSB:`HGD_SNK_LSB];
        end
    end
    // closed bits keep their stored value
    drv_ctrl_d = (drv_ctrl_d & ~drv_we)
               | (hwdata[10:0] & drv_we);
end

// state flops; every next value comes from the block above
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        lock_q     <= `HGD_RST_LOCK;
        src_q      <= `HGD_RST_SRC;
        snk_q      <= `HGD_RST_SNK;
        drv_ctrl_q <= `HGD_RST_DRV_CTRL;
    end
    else
    begin
        lock_q     <= lock_d;
        src_q      <= src_d;
        snk_q      <= snk_d;
        drv_ctrl_q <= drv_ctrl_d;
    end
end

// ==========================================================
// outputs
// the decoder is pure logic on the code flops, so currents settle with the codes
assign hs_source_current_code = src_q;
assign hs_sink_current_code   = snk_q;
assign drv_ctrl_bits          = drv_ctrl_q;
assign cfg_locked             = locked;

hgd_cur_decode u_dec (
    .src_code (src_q),
    .snk_code (snk_q),
    .src_ma   (hs_source_current_ma),
    .snk_ma   (hs_sink_current_ma)
);

endmodule // hgd_top

// ---- tb/hgd_host.sv ----
// hgd_host.sv: ahb-lite master standing in for host software
// assumes: one slave, its hreadyout feeds hready
`timescale 1ns/100ps
module hgd_host (
    input  logic        hclk,
    input  logic        hready,
    input  logic [31:0] hrdata,
    output logic [31:0] haddr = 32'h0,
    output logic [1:0]  htrans = 2'h0,
    output logic        hwrite = 1'b0,
    output logic [31:0] hwdata = 32'h0
);
    // ==========================================
    // single word transfer, waits on hready
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // released data bus flips so a stale value cannot pass
        hwdata <= ~d;
    endtask
endmodule // hgd_host

// ---- tb/hgd_monitor.sv ----
// hgd_monitor.sv: lock and bus checks on hgd_top ports
// assumes: bound to hgd_top, one clock, hready tied to hreadyout
`timescale 1ns/100ps
module hgd_monitor (
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic [31:0] hwdata,
    input logic        hreadyout,
    input logic        hresp,
    input logic [31:0] hrdata,
    input logic [3:0]  hs_source_current_code,
    input logic [3:0]  hs_sink_current_code,
    input logic [10:0] drv_ctrl_bits,
    input logic        cfg_locked
);
    // ==========================================
    // data-phase flags
    logic cfg_q;
    logic drv_q;
    wire  take = hsel && hready && htrans[1] && hwrite;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_q <= 1'b0;
            drv_q <= 1'b0;
        end
        else
        begin
            cfg_q <= take && haddr[7:0] == 8'h0C;
            drv_q <= take && haddr[7:0] == 8'h08;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_ok: assert property (hreadyout && !hresp && hrdata[31:11] == 21'h0)
        else $error("bus answer bad");
    a_lock_enter: assert property (cfg_q && !cfg_locked && hwdata[10:8] == 3'h6 |=> cfg_locked)
        else $error("lock missed");
    a_unlocked_other: assert property (cfg_q && !cfg_locked && hwdata[10:8] != 3'h6
        |=> !cfg_locked && hs_source_current_code == $past(hwdata[7:4])) else $error("bad write");
    a_lock_exit: assert property (cfg_q && cfg_locked && hwdata[10:8] == 3'h3 |=> !cfg_locked)
        else $error("unlock missed");
    a_locked_hold: assert property (cfg_q && cfg_locked && hwdata[10:8] != 3'h3
        |=> cfg_locked && $stable(hs_sink_current_code)) else $error("locked code moved");
    a_drv_guard: assert property (drv_q && cfg_locked
        |=> $stable(drv_ctrl_bits[10:3]) && drv_ctrl_bits[2:1] == $past(hwdata[2:1]))
        else $error("drv guard");
    a_clear_pulse: assert property (drv_ctrl_bits[0] && !drv_q |=> !drv_ctrl_bits[0])
        else $error("clear bit stuck");
    a_flag_stable: assert property (!cfg_q ##1 !cfg_q |-> $stable(cfg_locked))
        else $error("lock moved");
endmodule // hgd_monitor

// ---- tb/hgd_top_tb.sv ----
// hgd_top_tb.sv: register, lock and decode tests for hgd_top
// assumes: hgd_host masters the bus, hgd_monitor bound below
`timescale 1ns/100ps
`include "hgd_defs.vh"
`define CHK(nm, e, g) \
    begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module hgd_top_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [3:0]  hs_source_current_code, hs_sink_current_code;
    wire  [10:0] hs_source_current_ma, drv_ctrl_bits;
    wire  [11:0] hs_sink_current_ma;
    wire         hwrite, hreadyout, hresp, cfg_locked;
    int          n_errors = 0;
    int          total_checks = 0;
    logic [11:0] src_t [16] = '{12'h032, 12'h032, 12'h064, 12'h096, 12'h12C, 12'h15E, 12'h190,
        12'h1C2, 12'h226, 12'h258, 12'h28A, 12'h2BC, 12'h352, 12'h384, 12'h3B6, 12'h3E8};
    logic [11:0] snk_t [16] = '{12'h064, 12'h064, 12'h0C8, 12'h12C, 12'h258, 12'h2BC, 12'h320,
        12'h384, 12'h44C, 12'h4B0, 12'h514, 12'h578, 12'h6A4, 12'h708, 12'h76C, 12'h7D0};
    always #5 hclk = ~hclk;
    hgd_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hs_source_current_code,
        .hs_sink_current_code, .hs_source_current_ma, .hs_sink_current_ma, .drv_ctrl_bits,
        .cfg_locked);
    hgd_host host (.hclk, .hready(hreadyout), .hrdata, .haddr, .htrans, .hwrite, .hwdata);
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        `CHK("rdata", e, q)
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
    // ==========================================
    // tests
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`HGD_ADDR_HS_CFG, 32'h3FF);
        rd(`HGD_ADDR_DRV_CTRL, 32'h0);
        wr(32'h10, 32'hFFFF_FFFF);
        rd(32'h10, 32'h0);
        $display("reset and map test done");
        for (int i = 0; i < 16; i++)
        begin
            wr(`HGD_ADDR_HS_CFG, {21'h0, 3'h3, i[3:0], ~i[3:0]});
            rd(`HGD_ADDR_HS_CFG, {21'h0, 3'h3, i[3:0], ~i[3:0]});
            `CHK("src_code", i[3:0], hs_source_current_code)
            `CHK("snk_code", 4'hF - i[3:0], hs_sink_current_code)
            `CHK("src_ma", src_t[i], hs_source_current_ma)
            `CHK("snk_ma", snk_t[15 - i], hs_sink_current_ma)
        end
        $display("decode test done");
        wr(`HGD_ADDR_HS_CFG, 32'h5A5);
        rd(`HGD_ADDR_HS_CFG, 32'h3A5);
        wr(`HGD_ADDR_HS_CFG, 32'h623);
        rd(`HGD_ADDR_HS_CFG, 32'h623);
        `CHK("locked", 1'b1, cfg_locked)
        wr(`HGD_ADDR_HS_CFG, 32'h5FF);
        rd(`HGD_ADDR_HS_CFG, 32'h623);
        wr(`HGD_ADDR_DRV_CTRL, 32'h7FF);
        rd(`HGD_ADDR_DRV_CTRL, 32'h006);
        wr(`HGD_ADDR_HS_CFG, 32'h311);
        rd(`HGD_ADDR_HS_CFG, 32'h323);
        `CHK("locked", 1'b0, cfg_locked)
        wr(`HGD_ADDR_DRV_CTRL, 32'h7F8);
        rd(`HGD_ADDR_DRV_CTRL, 32'h7F8);
        $display("lock test done");
        wrap_up();
    end
endmodule // hgd_top_tb
bind hgd_top hgd_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hreadyout, .hresp, .hrdata, .hs_source_current_code, .hs_sink_current_code,
    .drv_ctrl_bits, .cfg_locked);
